//--- flash_device_model.sv
// behavioural parallel flash answering the host controller
`timescale 1ns/1ns
module flash_device_model #(
   parameter int unsigned prog_ns = 400,
   parameter logic [15:0] maker_code = 16'h0001, // arbitrary value
   parameter logic [15:0] device_code = 16'h2222 // arbitrary value
)(
   input wire logic [19:0] addr,
   input wire logic [15:0] dq,
   output logic [15:0] dq_q,
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic reset_n,
   input wire logic byte_n,
   output logic rb_n
);
   logic [15:0] mem [256];
   logic [15:0] qtab [13] = '{16'h0050, 16'h0052, 16'h0049, 16'h0031,
      16'h0030, 16'h0000, 16'h0002, 16'h0001, 16'h0001, 16'h0004,
      16'h0000, 16'h0000, 16'h0000};
   logic [19:0] la;
   logic [2:0] st;
   logic [15:0] rd;
   logic busy;
   logic tog;
   wire wr = !ce_n && !we_n && oe_n;
   initial
   begin
      st = 3'h0;
      busy = 1'h0;
      tog = 1'h0;
      rb_n = 1'h1;
      dq_q = 16'h0000;
      for (int i = 0; i < 256; i++) mem[i] = {8'ha5, i[7:0]};
   end
   // =====================================================
   // command decoding, codes are the common defaults
   always @(posedge wr) la = addr;
   // strobes low at time zero are a power-up artefact, not a command
   always @(negedge wr)
   if ($time > 0 && reset_n && !busy)
   begin
      // the fourth program cycle carries user data, never a reset code
      if (dq == 16'h00f0 && st != 3'h3) st = 3'h0;
      else case (st)
         3'h0: st = (la == 20'h0_0555 && dq == 16'h00aa) ? 3'h1 :
            (la == 20'h0_0055 && dq == 16'h0098) ? 3'h5 : 3'h0;
         3'h1: st = (la == 20'h0_02aa && dq == 16'h0055) ? 3'h2 : 3'h0;
         3'h2: st = (la != 20'h0_0555) ? 3'h0 : (dq == 16'h00a0) ? 3'h3 :
            (dq == 16'h0090) ? 3'h4 : 3'h0;
         3'h3:
         begin
            mem[la[7:0]] &= byte_n ? dq : {8'hff, dq[7:0]};
            st = 3'h0;
            busy = 1'h1;
            rb_n = 1'h0;
         end
         default: ;
      endcase
   end
   always @(posedge busy)
   begin
      #prog_ns;
      busy = 1'h0;
      rb_n = 1'h1;
   end
   always @(negedge reset_n)
   begin
      busy = 1'h0;
      rb_n = 1'h1;
      st = 3'h0;
   end
   always @(negedge oe_n) if (!ce_n) tog = !tog;
   // =====================================================
   // read path; a released bus inverts its last value each time rd, ce_n or oe_n changes
   always @*
   begin
      if (busy) rd = {8'h00, !mem[la[7:0]][7], tog, 6'h00};
      else if (st == 3'h4) case (addr[7:0])
         8'h00: rd = maker_code;
         8'h01: rd = device_code;
         8'h02, 8'h04: rd = {15'h0000, addr[19:12] == 8'h01};
         default: rd = 16'h0000;
      endcase
      else if (st == 3'h5) rd = (addr[7:0] >= 8'h40 && addr[7:0] <= 8'h4c) ?
         qtab[addr[7:0] - 8'h40] : 16'h0000;
      else rd = byte_n ? mem[addr[7:0]] : {8'h00, mem[addr[7:0]][7:0]};
   end
   always @(rd, ce_n, oe_n) dq_q = (!ce_n && !oe_n) ? rd : ~dq_q;
endmodule : flash_device_model

//--- flash_host.sv
// host controller that drives a parallel flash through its pins
`timescale 1ns/1ns
module flash_host #(
   parameter int unsigned aw = 20,
   parameter int unsigned dw = 16,
   parameter logic [aw-1:0] unlock1_addr = 20'h0_0555,
   parameter logic [aw-1:0] unlock2_addr = 20'h0_02aa,
   parameter logic [dw-1:0] unlock1_data = 16'h00aa,
   parameter logic [dw-1:0] unlock2_data = 16'h0055,
   parameter logic [dw-1:0] reset_code = 16'h00f0,
   parameter logic [dw-1:0] autoselect_code = 16'h0090,
   parameter logic [dw-1:0] program_code = 16'h00a0,
   parameter logic [dw-1:0] query_code = 16'h0098,
   parameter logic [aw-1:0] query_addr = 20'h0_0055
)(
   input wire logic clk,
   input wire logic nrst,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire flash_host_pkg::op_type cmd_op,
   input wire logic [aw-1:0] cmd_addr,
   input wire logic [dw-1:0] cmd_wdata,
   input wire logic cmd_byte_mode,
   output logic rsp_valid,
   output logic [dw-1:0] rsp_rdata,
   output logic prog_fail,
   output logic [aw-1:0] flash_addr,
   input wire logic [dw-1:0] flash_dq_in,
   output logic [dw-1:0] flash_dq_out,
   output logic flash_dq_oe,
   output logic flash_ce_n,
   output logic flash_we_n,
   output logic flash_oe_n,
   output logic flash_reset_n,
   output logic flash_byte_n,
   input wire logic ready_busy_n
);
   // =====================================================
   // pin synchronisers
   logic [dw-1:0] dq_s1_q, dq_s2_q;
   logic rb_s1_q, rb_s2_q;
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         dq_s1_q <= '0;
         dq_s2_q <= '0;
         rb_s1_q <= 1'b1;
         rb_s2_q <= 1'b1;
      end
      else
      begin
         dq_s1_q <= flash_dq_in;
         dq_s2_q <= dq_s1_q;
         rb_s1_q <= ready_busy_n;
         rb_s2_q <= rb_s1_q;
      end
   end

   // =====================================================
   // bus cycle sequencer
   typedef enum logic [2:0] {
      st_idle, st_setup, st_pulse, st_hold, st_poll, st_done
   } state_type;
   localparam int unsigned nseq = 4;
   state_type state_q, state_d;
   logic [3:0] cnt_q, cnt_d;
   logic [2:0] step_q, step_d;
   logic [2:0] last_q, last_d;
   logic rd_q, rd_d;
   logic [aw-1:0] addr_q, addr_d;
   logic [dw-1:0] dout_q, dout_d;
   logic [dw-1:0] rdata_q, rdata_d;
   logic ce_q, ce_d, we_q, we_d, oe_q, oe_d, hrst_q, hrst_d;
   logic byte_q, byte_d, fail_q, fail_d, rv_q, rv_d, drv_q, drv_d;
   flash_host_pkg::op_type op_q, op_d;
   logic [aw-1:0] uaddr_q;
   logic [dw-1:0] udata_q;

   // the unlock preamble is shared by program and autoselect paths; reset and query are single cycles
   function automatic logic [aw+dw-1:0] seq_word(
      input flash_host_pkg::op_type op, input logic [2:0] step,
      input logic [aw-1:0] ua, input logic [dw-1:0] ud);
      seq_word = {ua, ud};
      case (op)
         flash_host_pkg::op_reset: seq_word = {ua, reset_code};
         flash_host_pkg::op_query: seq_word = {query_addr, query_code};
         flash_host_pkg::op_autoselect, flash_host_pkg::op_program:
            case (step)
               3'd0: seq_word = {unlock1_addr, unlock1_data};
               3'd1: seq_word = {unlock2_addr, unlock2_data};
               3'd2: seq_word = {unlock1_addr,
                  op == flash_host_pkg::op_program ? program_code
                                                   : autoselect_code};
               default: seq_word = {ua, ud};
            endcase
         default: seq_word = {ua, ud};
      endcase
   endfunction : seq_word

   always_comb
   begin
      logic [aw+dw-1:0] w;
      w = '0;
      state_d = state_q;
      cnt_d = cnt_q;
      step_d = step_q;
      last_d = last_q;
      rd_d = rd_q;
      addr_d = addr_q;
      dout_d = dout_q;
      rdata_d = rdata_q;
      ce_d = ce_q;
      we_d = we_q;
      oe_d = oe_q;
      hrst_d = hrst_q;
      byte_d = byte_q;
      fail_d = fail_q;
      rv_d = 1'b0;
      op_d = op_q;
      case (state_q)
         st_idle:
            if (cmd_valid)
            begin
               op_d = cmd_op;
               step_d = 3'd0;
               cnt_d = '0;
               byte_d = cmd_byte_mode;
               fail_d = 1'b0;
               case (cmd_op)
                  flash_host_pkg::op_program: last_d = 3'(nseq - 1);
                  flash_host_pkg::op_autoselect: last_d = 3'd2;
                  default: last_d = 3'd0;
               endcase
               if (cmd_op == flash_host_pkg::op_hw_reset)
               begin
                  hrst_d = 1'b1;
                  state_d = st_hold;
               end
               else
               begin
                  rd_d = (cmd_op == flash_host_pkg::op_read);
                  state_d = st_setup;
               end
            end
         st_setup:
         begin
            w = seq_word(op_q, step_q, uaddr_q, udata_q);
            addr_d = rd_q ? uaddr_q : w[aw+dw-1:dw];
            dout_d = w[dw-1:0];
            cnt_d = cnt_q + 4'd1;
            if (cnt_q >= 4'(flash_host_pkg::setup_cyc))
            begin
               // strobes fall only after the address has settled, so the
               // device latches a stable address; oe stays high on writes
               ce_d = 1'b1;
               oe_d = rd_q;
               we_d = ~rd_q;
               cnt_d = '0;
               state_d = st_pulse;
            end
         end
         st_pulse:
         begin
            cnt_d = cnt_q + 4'd1;
            if (cnt_q >= 4'(flash_host_pkg::pulse_cyc))
            begin
               cnt_d = '0;
               we_d = 1'b0; // data taken on this we rise
               oe_d = 1'b0;
               ce_d = 1'b0;
               if (rd_q)
                  rdata_d = dq_s2_q;
               if (step_q == last_q)
                  state_d = (op_q == flash_host_pkg::op_program) ? st_poll
                                                                 : st_done;
               else
               begin
                  step_d = step_q + 3'd1;
                  state_d = st_setup;
               end
            end
         end
         st_hold:
         begin
            cnt_d = cnt_q + 4'd1;
            if (cnt_q >= 4'(flash_host_pkg::hw_reset_cyc))
            begin
               hrst_d = 1'b0;
               state_d = st_done;
            end
         end
         st_poll:
            // no commands go out while the device programs
            if (rb_s2_q && cnt_q >= 4'd3)
               state_d = st_done;
            else if (cnt_q < 4'd3)
               cnt_d = cnt_q + 4'd1;
         st_done:
         begin
            rv_d = 1'b1;
            state_d = st_idle;
         end
         default: state_d = st_idle;
      endcase
      drv_d = we_d | we_q; // data held past the we rise
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q <= st_idle;
         cnt_q <= '0;
         step_q <= '0;
         last_q <= '0;
         rd_q <= 1'b0;
         addr_q <= '0;
         dout_q <= '0;
         rdata_q <= '0;
         ce_q <= 1'b0;
         we_q <= 1'b0;
         oe_q <= 1'b0;
         hrst_q <= 1'b0;
         byte_q <= 1'b0;
         fail_q <= 1'b0;
         rv_q <= 1'b0;
         drv_q <= 1'b0;
         op_q <= flash_host_pkg::op_read;
         uaddr_q <= '0;
         udata_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         step_q <= step_d;
         last_q <= last_d;
         rd_q <= rd_d;
         addr_q <= addr_d;
         dout_q <= dout_d;
         rdata_q <= rdata_d;
         ce_q <= ce_d;
         we_q <= we_d;
         oe_q <= oe_d;
         hrst_q <= hrst_d;
         byte_q <= byte_d;
         fail_q <= fail_d;
         rv_q <= rv_d;
         drv_q <= drv_d;
         op_q <= op_d;
         if (state_q == st_idle && cmd_valid)
         begin
            uaddr_q <= cmd_addr;
            udata_q <= cmd_wdata;
         end
      end
   end

   assign cmd_ready = (state_q == st_idle);
   assign rsp_valid = rv_q;
   assign rsp_rdata = rdata_q;
   // program-fail flag; nothing sets it, so it is cleared at each command and stays low
   assign prog_fail = fail_q;
   assign flash_addr = addr_q;
   assign flash_dq_out = dout_q;
   assign flash_dq_oe = drv_q;
   assign flash_ce_n = ~ce_q;
   assign flash_we_n = ~we_q;
   assign flash_oe_n = ~oe_q;
   assign flash_reset_n = ~hrst_q;
   assign flash_byte_n = ~byte_q;

   // =====================================================
   // checks
   sequence write_strobe_s;
      (!flash_we_n && !flash_ce_n);
   endsequence
   write_needs_oe_a: assert property (@(posedge clk)
      disable iff (!nrst) write_strobe_s |-> flash_oe_n)
      else $error("write strobe with output enable low");
   dq_drive_a: assert property (@(posedge clk)
      disable iff (!nrst)
      flash_dq_oe |-> flash_oe_n && (!flash_we_n || $past(!flash_we_n)))
      else $error("data driven outside write cycle");
   busy_quiet_a: assert property (@(posedge clk)
      disable iff (!nrst) state_q == st_poll |-> flash_ce_n && flash_we_n)
      else $error("bus cycle during embedded program");
   prog_four_a: assert property (@(posedge clk)
      disable iff (!nrst)
      state_q == st_pulse && op_q == flash_host_pkg::op_program
      && step_q == 3'd3 |-> last_q == 3'd3)
      else $error("program sequence not four cycles");
   sequence cycle_active_s;
      !flash_ce_n;
   endsequence
   addr_hold_a: assert property (@(posedge clk)
      disable iff (!nrst)
      cycle_active_s ##1 cycle_active_s |-> $stable(flash_addr))
      else $error("address moved during a bus cycle");
endmodule : flash_host

//--- flash_host_pkg.sv
// constants for the host-side flash command controller
package flash_host_pkg;
   // =====================================================
   // bus timing, in clock cycles at 25 MHz
   localparam int unsigned clk_period_ns = 40;
   localparam int unsigned setup_ns = 40;
   localparam int unsigned pulse_ns = 80;
   localparam int unsigned setup_cyc =
      (setup_ns + clk_period_ns - 1) / clk_period_ns;
   localparam int unsigned pulse_cyc =
      (pulse_ns + clk_period_ns - 1) / clk_period_ns;
   localparam int unsigned hw_reset_ns = 500;
   localparam int unsigned hw_reset_cyc =
      (hw_reset_ns + clk_period_ns - 1) / clk_period_ns;
   // =====================================================
   // autoselect and query offsets
   localparam logic [7:0] as_maker_ofs = 8'h00;
   localparam logic [7:0] as_device_ofs = 8'h01;
   localparam logic [7:0] as_prot_word_ofs = 8'h02;
   localparam logic [7:0] as_prot_byte_ofs = 8'h04;
   localparam logic [7:0] query_sig_ofs = 8'h40;
   localparam logic [15:0] query_sig_p = 16'h0050;
   localparam logic [15:0] query_major = 16'h0031;
   // =====================================================
   // status bit positions on the data bus
   localparam int unsigned polling_pos = 7;
   localparam int unsigned toggle_pos = 6;
   localparam int unsigned limit_pos = 5;
   // =====================================================
   // user command codes
   typedef enum logic [2:0] {
      op_read, op_reset, op_program, op_autoselect, op_query, op_hw_reset
   } op_type;
endpackage : flash_host_pkg

//--- flash_host_tb.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ns
module flash_host_tb;
   logic clk, nrst, cmd_valid, cmd_byte_mode;
   flash_host_pkg::op_type cmd_op;
   logic [19:0] cmd_addr, flash_addr;
   logic [15:0] cmd_wdata, rsp_rdata, flash_dq_out, dev_q, dq_bus;
   logic cmd_ready, rsp_valid, prog_fail, flash_dq_oe, flash_ce_n;
   logic flash_we_n, flash_oe_n, flash_reset_n, flash_byte_n, rb_n;
   int fails = 0;
   int samples_checked = 0;
   logic [15:0] qexp [13] = '{16'h0050, 16'h0052, 16'h0049, 16'h0031,
      16'h0030, 16'h0000, 16'h0002, 16'h0001, 16'h0001, 16'h0004,
      16'h0000, 16'h0000, 16'h0000};
   assign dq_bus = flash_dq_oe ? flash_dq_out : dev_q;
   flash_host dut (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_byte_mode(cmd_byte_mode),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .prog_fail(prog_fail),
      .flash_addr(flash_addr), .flash_dq_in(dq_bus),
      .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
      .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
      .flash_oe_n(flash_oe_n), .flash_reset_n(flash_reset_n),
      .flash_byte_n(flash_byte_n), .ready_busy_n(rb_n));
   flash_device_model dev (.addr(flash_addr), .dq(dq_bus), .dq_q(dev_q),
      .ce_n(flash_ce_n), .we_n(flash_we_n), .oe_n(flash_oe_n),
      .reset_n(flash_reset_n), .byte_n(flash_byte_n), .rb_n(rb_n));
   // =====================================================
   // access tasks
   task automatic final_report;
      if (fails == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : final_report
   task automatic run(input flash_host_pkg::op_type op,
      input logic [19:0] a, input logic [15:0] d, input logic bm);
      int n;
      @(posedge clk);
      cmd_valid <= 1'h1;
      cmd_op <= op;
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_byte_mode <= bm;
      do @(posedge clk); while (cmd_ready !== 1'h1);
      cmd_valid <= 1'h0;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (rsp_valid !== 1'h1 && n < 5000);
      if (n >= 5000) fails++;
   endtask : run
   task automatic rd(input logic [19:0] a, input logic bm,
      input logic [15:0] exp);
      run(flash_host_pkg::op_read, a, 16'h0000, bm);
      samples_checked++;
      if (rsp_rdata !== exp)
      begin
         $display("unexpected at %0t: got %h want %h", $time, rsp_rdata, exp);
         fails++;
      end
   endtask : rd
   // =====================================================
   // clock, watchdog and tests
   initial
   begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      final_report;
   end
   initial
   begin
      nrst = 1'h0;
      cmd_valid = 1'h0;
      cmd_op = flash_host_pkg::op_read;
      cmd_addr = 20'h0_0000;
      cmd_wdata = 16'h0000;
      cmd_byte_mode = 1'h0;
      repeat (2) @(posedge clk);
      nrst <= 1'h1;
      rd(20'h0_0005, 1'h0, 16'ha505);
      run(flash_host_pkg::op_program, 20'h0_0010, 16'h1234, 1'h0);
      samples_checked++;
      if (prog_fail !== 1'h0)
      begin
         $display("unexpected at %0t: got %h want %h", $time, prog_fail, 1'h0);
         fails++;
      end
      rd(20'h0_0010, 1'h0, 16'ha510 & 16'h1234);
      run(flash_host_pkg::op_program, 20'h0_0010, 16'hffff, 1'h0);
      rd(20'h0_0010, 1'h0, 16'ha510 & 16'h1234);
      run(flash_host_pkg::op_program, 20'h0_0020, 16'h0f0f, 1'h1);
      rd(20'h0_0020, 1'h1, 16'h0000);
      rd(20'h0_0020, 1'h0, 16'ha500);
      run(flash_host_pkg::op_autoselect, 20'h0_0000, 16'h0000, 1'h0);
      rd(20'h0_0000, 1'h0, 16'h0001);
      rd(20'h0_0001, 1'h0, 16'h2222);
      rd(20'h0_1002, 1'h0, 16'h0001);
      rd(20'h0_0002, 1'h0, 16'h0000);
      rd(20'h0_1004, 1'h1, 16'h0001);
      rd(20'h0_0005, 1'h0, 16'h0000);
      run(flash_host_pkg::op_reset, 20'h0_0000, 16'h0000, 1'h0);
      rd(20'h0_0005, 1'h0, 16'ha505);
      run(flash_host_pkg::op_query, 20'h0_0000, 16'h0000, 1'h0);
      for (int i = 0; i < 13; i++)
         rd(20'h0_0040 + 20'(i), 1'h0, qexp[i]);
      run(flash_host_pkg::op_reset, 20'h0_0000, 16'h0000, 1'h0);
      run(flash_host_pkg::op_hw_reset, 20'h0_0000, 16'h0000, 1'h0);
      rd(20'h0_0007, 1'h0, 16'ha507);
      final_report;
   end
endmodule : flash_host_tb
